// file: hdl/absolute_quadrature_output_groups.sv
// Six open-drain outputs in two groups with absolute quadrature emulation
`timescale 1ns/1ps
`include "aq_cfg.svh"
module absolute_quadrature_output_groups
    import aq_pkg::*;
#(
    parameter int TICK_CYC = `AQ_TICK_CYC, // Refresh and delay tick
    parameter int FAST_CYC = `AQ_FAST_CYC, // Shortest state period
    parameter int SLOW_CYC = `AQ_SLOW_CYC, // Longest state period
    parameter int TW = 19 // Timer width
) (
    input wire logic i_ref_clk, // System clock, 200 MHz
    input wire logic i_nrst, // Async reset, active low
    input wire mode_e i_group0_mode, // Group 0 output mode
    input wire mode_e i_group1_mode, // Group 1 output mode
    input wire logic [1:0] i_group0_axis, // Group 0 axis, 0 to 2
    input wire logic [1:0] i_group1_axis, // Group 1 axis, 0 to 2
    input wire logic [2:0][15:0] i_axis_pos, // Axis position in states
    input wire logic [2:0][15:0] i_zero_pos, // Zero reference in states
    input wire logic [13:0] i_cpr, // Cycles per revolution
    input wire logic [15:0] i_startup_ticks, // Startup delay, 0 = default
    input wire logic [TW-1:0] i_state_period, // Cycles per state
    input wire logic [5:0] i_manual_bits, // Manual mode levels
    input wire logic [1:0] i_below_limit_flag, // Tilt below limit, per group
    input wire logic [1:0] i_hysteresis_latch_out, // Tilt latch, per group
    input wire logic [1:0] i_above_limit_flag, // Tilt above limit, per group
    input wire logic [1:0] i_pwm_level, // PWM level, per group
    output logic [5:0] o_drain_on, // Drain switch on, line pulled low
    output logic [5:0] o_drain_level, // Driven level, always low
    output logic o_startup_done // Startup delay has expired
);
    //////////////////////////////////////////////////////////////////////
    // Configuration clamps
    //////////////////////////////////////////////////////////////////////
    logic [15:0] span;
    logic [15:0] next_span;
    logic [TW-1:0] period;
    logic [TW-1:0] next_period;
    logic [15:0] delay_limit;
    logic [15:0] next_delay_limit;
    logic [13:0] cpr_eff;

    // Clamp resolution, rate and delay into their legal ranges
    always_comb begin
        cpr_eff = i_cpr;
        if (i_cpr < 14'(`AQ_CPR_MIN)) begin
            cpr_eff = 14'(`AQ_CPR_MIN);
        end else if (i_cpr > 14'(`AQ_CPR_MAX)) begin
            cpr_eff = 14'(`AQ_CPR_MAX);
        end
        next_span = 16'(cpr_eff) * 16'(`AQ_STATES_PER_CYC);
        next_period = i_state_period;
        if (i_state_period < TW'(FAST_CYC)) begin
            next_period = TW'(FAST_CYC);
        end else if (i_state_period > TW'(SLOW_CYC)) begin
            next_period = TW'(SLOW_CYC);
        end
        next_delay_limit = i_startup_ticks;
        if (i_startup_ticks == 16'h0) begin
            next_delay_limit = 16'(`AQ_DELAY_DEF_TK);
        end else if (i_startup_ticks < 16'(`AQ_DELAY_MIN_TK)) begin
            next_delay_limit = 16'(`AQ_DELAY_MIN_TK);
        end else if (i_startup_ticks > 16'(`AQ_DELAY_MAX_TK)) begin
            next_delay_limit = 16'(`AQ_DELAY_MAX_TK);
        end
    end

    // Configuration registers
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            span <= 16'(`AQ_CPR_MAX * `AQ_STATES_PER_CYC);
            period <= TW'(FAST_CYC);
            delay_limit <= 16'(`AQ_DELAY_DEF_TK);
        end else begin
            span <= next_span;
            period <= next_period;
            delay_limit <= next_delay_limit;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Timing: refresh tick and state slot
    //////////////////////////////////////////////////////////////////////
    logic frame_tick;
    logic step_tick;

    // Fixed 1.5625 ms tick, also the 640 Hz refresh
    period_timer #(.W(TW)) u_frame_timer (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_period(TW'(TICK_CYC)),
        .o_tick(frame_tick)
    );

    // Programmable state slot
    period_timer #(.W(TW)) u_step_timer (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_period(period),
        .o_tick(step_tick)
    );

    //////////////////////////////////////////////////////////////////////
    // Startup delay
    //////////////////////////////////////////////////////////////////////
    logic [15:0] delay_count;
    logic [15:0] next_delay_count;
    logic started;
    logic next_started;

    // Count delay ticks until the programmed limit
    always_comb begin
        next_delay_count = delay_count;
        next_started = started;
        if (!started) begin
            if (delay_count >= delay_limit) begin
                next_started = 1'b1;
            end else if (frame_tick) begin
                next_delay_count = delay_count + 16'h1;
            end
        end
    end

    // Delay registers
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            delay_count <= '0;
            started <= 1'b0;
        end else begin
            delay_count <= next_delay_count;
            started <= next_started;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Quadrature channels
    //////////////////////////////////////////////////////////////////////
    logic [1:0][15:0] target;
    logic [1:0][1:0] axis_sel;
    logic [1:0] quad_a;
    logic [1:0] quad_b;
    logic [1:0] quad_index;

    // Target relative to the chosen zero reference
    always_comb begin
        axis_sel[0] = (i_group0_axis > 2'h2) ? 2'h2 : i_group0_axis;
        axis_sel[1] = (i_group1_axis > 2'h2) ? 2'h2 : i_group1_axis;
        for (int g = 0; g < 2; g++) begin
            target[g] = fwd_dist(i_axis_pos[axis_sel[g]],
                                 i_zero_pos[axis_sel[g]], span);
        end
    end

    // One tracker per group, independent of settings traffic
    for (genvar g = 0; g < 2; g++) begin : g_chan
        quad_channel u_chan (
            .i_ref_clk(i_ref_clk),
            .i_nrst(i_nrst),
            .i_start(started),
            .i_step(step_tick),
            .i_frame(frame_tick),
            .i_target(target[g]),
            .i_span(span),
            .o_a(quad_a[g]),
            .o_b(quad_b[g]),
            .o_index(quad_index[g])
        );
    end

    //////////////////////////////////////////////////////////////////////
    // Output mapping
    //////////////////////////////////////////////////////////////////////
    logic [5:0] next_drain_on;
    mode_e grp_mode [2];

    // Route each group by its mode
    always_comb begin
        grp_mode[0] = i_group0_mode;
        grp_mode[1] = i_group1_mode;
        next_drain_on = '0;
        for (int g = 0; g < 2; g++) begin
            case (grp_mode[g])
                MODE_MANUAL: begin
                    next_drain_on[3*g +: 3] = i_manual_bits[3*g +: 3];
                end
                MODE_QUAD: begin
                    next_drain_on[3*g +: 3] =
                        {quad_index[g], quad_b[g], quad_a[g]};
                end
                MODE_TILT: begin
                    next_drain_on[3*g +: 3] = {i_above_limit_flag[g],
                        i_hysteresis_latch_out[g], i_below_limit_flag[g]};
                end
                MODE_PWM: begin
                    if (g == 0) begin
                        next_drain_on[`AQ_PWM_BIT_G0] = i_pwm_level[0];
                    end else begin
                        next_drain_on[3 + `AQ_PWM_BIT_G1] = i_pwm_level[1];
                    end
                end
                default: next_drain_on[3*g +: 3] = 3'h0;
            endcase
        end
    end

    // Asserted bit turns the drain on and pulls the line low
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_drain_on <= `AQ_DRAIN_RST;
            o_drain_level <= 6'h0;
            o_startup_done <= 1'b0;
        end else begin
            o_drain_on <= next_drain_on;
            o_drain_level <= 6'h0;
            o_startup_done <= started;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Checks
    //////////////////////////////////////////////////////////////////////
    property p_pwm_zero;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        ((i_group0_mode == MODE_PWM)
            |=> (o_drain_on[0] == 1'b0 && o_drain_on[2] == 1'b0))
        and ((i_group1_mode == MODE_PWM)
            |=> (o_drain_on[5:4] == 2'h0));
    endproperty
    a_pwm_zero: assert property (p_pwm_zero) else $error("pwm spare on");

    property p_pwm_bit;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (i_group1_mode == MODE_PWM) |=> (o_drain_on[3] == $past(i_pwm_level[1]));
    endproperty
    a_pwm_bit: assert property (p_pwm_bit) else $error("pwm bit wrong");

    property p_quad_map;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (i_group0_mode == MODE_QUAD)
            |=> (o_drain_on[2:0] == $past({quad_index[0], quad_b[0], quad_a[0]}));
    endproperty
    a_quad_map: assert property (p_quad_map) else $error("quad map wrong");

    property p_rate;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (period >= TW'(FAST_CYC)) && (period <= TW'(SLOW_CYC));
    endproperty
    a_rate: assert property (p_rate) else $error("rate out of range");

    property p_delay;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        $rose(started) |-> $past(delay_count) >= $past(delay_limit);
    endproperty
    a_delay: assert property (p_delay) else $error("delay ended early");

    property p_held;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (!started && i_group0_mode == MODE_QUAD)
            |=> (o_drain_on[2:0] == 3'h4);
    endproperty
    a_held: assert property (p_held) else $error("startup hold broken");

    property p_span;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (span >= 16'(`AQ_STATES_PER_CYC))
            && (span <= 16'(`AQ_CPR_MAX * `AQ_STATES_PER_CYC));
    endproperty
    a_span: assert property (p_span) else $error("span out of range");

    property p_tick_gap;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        frame_tick |=> !frame_tick [*2];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick too close");
endmodule

// file: hdl/aq_cfg.svh
// Timing and range constants for the absolute quadrature output groups
`ifndef AQ_CFG_SVH
`define AQ_CFG_SVH

// System clock
`define AQ_CLK_HZ 200000000
`define AQ_CLK_NS 5

// Position refresh tick, also the startup delay step (1.5625 ms)
`define AQ_TICK_NS 1562500
`define AQ_TICK_CYC (`AQ_TICK_NS / `AQ_CLK_NS)

// State emission rate limits in states per second
`define AQ_FAST_HZ 6900
`define AQ_SLOW_HZ 770
// Shortest state period rounds up, longest rounds down
`define AQ_FAST_CYC ((`AQ_CLK_HZ + `AQ_FAST_HZ - 1) / `AQ_FAST_HZ)
`define AQ_SLOW_CYC (`AQ_CLK_HZ / `AQ_SLOW_HZ)

// Startup delay limits in milliseconds
`define AQ_DELAY_MIN_MS 2
`define AQ_DELAY_MAX_MS 102000
`define AQ_DELAY_DEF_MS 500
// Delay in ticks, least time rounds up, longest and default round down
`define AQ_MS_NS 64'd1000000
`define AQ_DELAY_MIN_TK \
    ((`AQ_DELAY_MIN_MS * `AQ_MS_NS + `AQ_TICK_NS - 1) / `AQ_TICK_NS)
`define AQ_DELAY_MAX_TK ((`AQ_DELAY_MAX_MS * `AQ_MS_NS) / `AQ_TICK_NS)
`define AQ_DELAY_DEF_TK ((`AQ_DELAY_DEF_MS * `AQ_MS_NS) / `AQ_TICK_NS)

// Resolution limits in cycles per revolution, four states per cycle
`define AQ_CPR_MIN 1
`define AQ_CPR_MAX 9000
`define AQ_STATES_PER_CYC 4

// Drain pattern during reset: both index lines asserted
`define AQ_DRAIN_RST 6'h24

// Bit position of the PWM line inside each group
`define AQ_PWM_BIT_G0 1
`define AQ_PWM_BIT_G1 0

`endif

// file: hdl/aq_pkg.sv
// Types and helper functions for the absolute quadrature output groups
package aq_pkg;

    // Output mode of one group
    typedef enum logic [1:0] {
        MODE_MANUAL,
        MODE_QUAD,
        MODE_TILT,
        MODE_PWM
    } mode_e;

    // Quadrature channel sequence
    typedef enum logic [1:0] {
        ST_WAIT,
        ST_IDX_LOW,
        ST_IDX_HIGH,
        ST_TRACK
    } chan_state_e;

    // Forward distance from one position to another on a circle of span
    function automatic logic [15:0] fwd_dist(input logic [15:0] to,
                                             input logic [15:0] from,
                                             input logic [15:0] span);
        logic [16:0] wrap;
        wrap = {1'b0, to} + {1'b0, span} - {1'b0, from};
        if (to >= from) begin
            return to - from;
        end
        return wrap[15:0];
    endfunction

    // Phase pair {b, a} for a position, one bit changes per step
    function automatic logic [1:0] gray_ba(input logic [1:0] pos);
        return {pos[1], pos[1] ^ pos[0]};
    endfunction

endpackage

// file: hdl/period_timer.sv
// Free running timer giving a one cycle pulse every period cycles
`timescale 1ns/1ps
module period_timer #(
    parameter int W = 19
) (
    input wire logic i_ref_clk, // System clock
    input wire logic i_nrst, // Async reset, active low
    input wire logic [W-1:0] i_period, // Period in cycles, at least 1
    output logic o_tick // One cycle pulse
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic next_tick;

    // Wrap when the period is reached
    always_comb begin
        next_tick = 1'b0;
        next_count = count + 1'b1;
        if (next_count >= i_period) begin
            next_count = '0;
            next_tick = 1'b1;
        end
    end

    // State registers
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            count <= '0;
            o_tick <= 1'b0;
        end else begin
            count <= next_count;
            o_tick <= next_tick;
        end
    end
endmodule

// file: hdl/quad_channel.sv
// Absolute quadrature tracker for one output group
`timescale 1ns/1ps
module quad_channel
    import aq_pkg::*;
(
    input wire logic i_ref_clk, // System clock
    input wire logic i_nrst, // Async reset, active low
    input wire logic i_start, // Startup delay has expired
    input wire logic i_step, // One state slot of the emission rate
    input wire logic i_frame, // Position refresh tick
    input wire logic [15:0] i_target, // Absolute position in states
    input wire logic [15:0] i_span, // States per revolution
    output logic o_a, // Phase A
    output logic o_b, // Phase B
    output logic o_index // Index
);
    chan_state_e state;
    chan_state_e next_state;
    logic [15:0] count;
    logic [15:0] next_count;
    logic [15:0] goal;
    logic [15:0] next_goal;
    logic [15:0] up_dist;
    logic [1:0] next_ba;
    logic next_index;

    // Sequence: wait, clear the counter with index, then track the goal
    always_comb begin
        next_state = state;
        next_count = count;
        next_goal = goal;
        up_dist = fwd_dist(goal, count, i_span);
        if (i_frame && i_target < i_span) begin
            next_goal = i_target;
        end
        case (state)
            ST_WAIT: begin
                if (i_start) begin
                    next_state = ST_IDX_LOW;
                end
            end
            ST_IDX_LOW: begin
                if (i_step) begin
                    next_state = ST_IDX_HIGH;
                end
            end
            ST_IDX_HIGH: begin
                if (i_step) begin
                    next_state = ST_TRACK;
                    next_count = '0;
                end
            end
            ST_TRACK: begin
                if (i_step && up_dist != 16'h0) begin
                    // Shorter way round wins
                    if (up_dist <= (i_span >> 1)) begin
                        next_count = count + 16'h1;
                        if (next_count >= i_span) begin
                            next_count = '0;
                        end
                    end else if (count == 16'h0) begin
                        next_count = i_span - 16'h1;
                    end else begin
                        next_count = count - 16'h1;
                    end
                end
            end
            default: next_state = ST_WAIT;
        endcase
        // Phases and index for the next state
        next_ba = 2'h0;
        next_index = 1'b0;
        case (next_state)
            ST_WAIT: next_index = 1'b1;
            ST_IDX_LOW: next_index = 1'b0;
            ST_IDX_HIGH: next_index = 1'b1;
            ST_TRACK: begin
                next_ba = gray_ba(next_count[1:0]);
                next_index = (next_count == 16'h0);
            end
            default: next_index = 1'b1;
        endcase
    end

    // State registers, index high from reset on
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= ST_WAIT;
            count <= '0;
            goal <= '0;
            o_a <= 1'b0;
            o_b <= 1'b0;
            o_index <= 1'b1;
        end else begin
            state <= next_state;
            count <= next_count;
            goal <= next_goal;
            o_a <= next_ba[0];
            o_b <= next_ba[1];
            o_index <= next_index;
        end
    end

    property p_hold;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (state == ST_WAIT) |-> (o_index && !o_a && !o_b);
    endproperty
    a_hold: assert property (p_hold) else $error("startup levels wrong");

    property p_gray;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        ({o_b, o_a} != $past({o_b, o_a})) |->
            ($countones({o_b, o_a} ^ $past({o_b, o_a})) == 1);
    endproperty
    a_gray: assert property (p_gray) else $error("two phases moved");

    property p_index;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (state == ST_TRACK && o_index) |-> (!o_a && !o_b && count == 16'h0);
    endproperty
    a_index: assert property (p_index) else $error("index off zero");

    property p_paced;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (state == ST_TRACK && !i_step) |=> $stable(count);
    endproperty
    a_paced: assert property (p_paced) else $error("step without slot");

    property p_short;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (state == ST_TRACK && i_step && up_dist != 16'h0
            && up_dist <= (i_span >> 1) && count + 16'h1 < i_span)
            |=> (count == $past(count) + 16'h1);
    endproperty
    a_short: assert property (p_short) else $error("wrong direction");
endmodule

// file: tb/quad_counter_model.sv
// External quadrature counter watching the three wires of one output group
`timescale 1ns/1ps
module quad_counter_model (
    input wire logic i_ref_clk, // System clock
    input wire logic i_nrst, // Power-up reset, active low
    input wire logic [2:0] i_line, // Wire levels {index, B, A}
    output int o_count, // Signed position count
    output int o_steps, // A/B changes seen
    output int o_bad, // Illegal patterns seen
    output int o_min_gap // Fewest cycles between two changes
);
    logic [2:0] sig;
    logic [1:0] prev;
    int gap;
    // An asserted output pulls its wire low
    assign sig = ~i_line;
    // Position of a {B, A} pair along the Gray cycle
    function automatic logic [1:0] gpos(input logic [1:0] ba);
        return {ba[1], ba[1] ^ ba[0]};
    endfunction
    ////////////////////////////////////////////////////////////////
    // Count every A/B change, clear on index
    always @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_count <= 12345; // Arbitrary count left from power-up
            o_steps <= 0;
            o_bad <= 0;
            o_min_gap <= 1000;
            gap <= 0;
            prev <= 2'h0;
        end else begin
            gap <= gap + 1;
            prev <= sig[1:0];
            if (sig[1:0] != prev) begin
                o_steps <= o_steps + 1;
                gap <= 1;
                if (gap < o_min_gap) begin
                    o_min_gap <= gap;
                end
                if (sig[1] != prev[1] && sig[0] != prev[0]) begin
                    o_bad <= o_bad + 1;
                end
                if (gpos(sig[1:0]) == gpos(prev) + 2'h1) begin
                    o_count <= o_count + 1;
                end else begin
                    o_count <= o_count - 1;
                end
            end
            if (sig[2]) begin
                o_count <= 0;
                if (sig[1:0] != 2'h0) begin
                    o_bad <= o_bad + 1;
                end
            end
        end
    end
endmodule

// file: tb/tb.sv
// Self-checking bench for the absolute quadrature output groups
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    $display("wrong value %s exp %0d got %0d", n, e, g); fail_count++; end end
module tb;
    import aq_pkg::*;
    logic i_ref_clk = 1'h0;
    logic i_nrst = 1'h0;
    mode_e m0 = MODE_QUAD;
    mode_e m1 = MODE_QUAD;
    mode_e mm;
    logic [1:0] ax1 = 2'h1;
    logic [2:0][15:0] pos = '0;
    logic [2:0][15:0] zero = '0;
    logic [15:0] sticks = 16'h2;
    logic [18:0] per = 19'h4;
    logic [5:0] man = 6'h0;
    logic [1:0] blw = 2'h0, hys = 2'h0, abv = 2'h0, pwm = 2'h0;
    logic [5:0] drain_on, drain_level;
    logic done;
    int seed = 80, fail_count = 0, samples_checked = 0;
    int cnt [2], steps [2], bad [2], gap [2];
    int r, k, g, lim, t0, t1, s0, s1;
    int cor [4] = '{10, 19, 10, 1};
    // Clock at 200 MHz
    always #2.5 i_ref_clk = ~i_ref_clk;
    absolute_quadrature_output_groups #(.TICK_CYC(20), .FAST_CYC(4),
        .SLOW_CYC(50)) dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_group0_mode(m0), .i_group1_mode(m1), .i_group0_axis(2'h0),
        .i_group1_axis(ax1), .i_axis_pos(pos), .i_zero_pos(zero),
        .i_cpr(14'h5), .i_startup_ticks(sticks), .i_state_period(per),
        .i_manual_bits(man), .i_below_limit_flag(blw),
        .i_hysteresis_latch_out(hys), .i_above_limit_flag(abv),
        .i_pwm_level(pwm), .o_drain_on(drain_on),
        .o_drain_level(drain_level), .o_startup_done(done));
    // One counter per group on the pulled-up wires
    for (genvar i = 0; i < 2; i++) begin : grp
        quad_counter_model mdl (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
            .i_line(~drain_on[3*i+:3] | drain_level[3*i+:3]),
            .o_count(cnt[i]), .o_steps(steps[i]), .o_bad(bad[i]),
            .o_min_gap(gap[i]));
    end
    ////////////////////////////////////////////////////////////////
    // Expected values, span is 4 states times 5 cycles
    function automatic int rnd();
        return $unsigned($random(seed)) % 20;
    endfunction
    function automatic int tgt(input int n);
        int a;
        a = n ? (ax1 > 2'h2 ? 2 : int'(ax1)) : 0;
        return (int'(pos[a]) - int'(zero[a]) + 20) % 20;
    endfunction
    function automatic int md(input int c);
        return ((c % 20) + 20) % 20;
    endfunction
    function automatic int sd(input int a, input int b);
        int d;
        d = (b - a + 20) % 20;
        return d > 10 ? 20 - d : d;
    endfunction
    function automatic logic [2:0] mx(input int n, input mode_e m);
        case (m)
            MODE_MANUAL: return man[3*n+:3];
            MODE_TILT: return {abv[n], hys[n], blw[n]};
            default: return n ? {2'h0, pwm[1]} : {1'h0, pwm[0], 1'h0};
        endcase
    endfunction
    task close_out;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Wait until the counters reach their targets, then compare
    task automatic settle(input int ng);
        int i;
        repeat (30) @(negedge i_ref_clk);
        for (i = 0; i < 2000 && (md(cnt[0]) != tgt(0) ||
            (ng > 1 && md(cnt[1]) != tgt(1))); i++) begin
            @(negedge i_ref_clk);
        end
        if (i == 2000) begin
            fail_count++;
            close_out();
        end
        for (i = 0; i < ng; i++) begin
            `CHK("count", tgt(i), md(cnt[i]))
            `CHK("index", tgt(i) == 0, drain_on[3*i+2])
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Startup twice, then tracking, then the other modes
    initial begin
        zero = {16'h0, 16'(rnd()), 16'(rnd())};
        pos = {16'h0, 16'(rnd()), 16'(rnd())};
        for (r = 0; r < 2; r++) begin
            sticks = r ? 16'h0 : 16'h2;
            lim = r ? 320 : 2;
            i_nrst = 1'h0;
            repeat (8) @(negedge i_ref_clk);
            `CHK("reset drains", 6'h24, drain_on)
            i_nrst = 1'h1;
            repeat (lim * 20 - 10) @(negedge i_ref_clk);
            `CHK("early drains", 6'h24, drain_on)
            `CHK("early done", 1'h0, done)
            repeat (20) @(negedge i_ref_clk);
            `CHK("done", 1'h1, done)
            settle(2);
            $display("test startup %0d done", lim);
        end
        for (k = 0; k < 12; k++) begin
            s0 = steps[0];
            s1 = steps[1];
            t0 = tgt(0);
            t1 = tgt(1);
            pos[0] = 16'(k < 4 ? (zero[0] + t0 + cor[k]) % 20 : rnd());
            pos[1] = 16'(rnd());
            pos[2] = 16'(rnd());
            ax1 = 2'(1 + k % 3);
            per = 19'($unsigned($random(seed)) % 64);
            settle(2);
            `CHK("steps0", sd(t0, tgt(0)), steps[0] - s0)
            `CHK("steps1", sd(t1, tgt(1)), steps[1] - s1)
        end
        `CHK("bad1", 0, bad[1])
        `CHK("gap1", 1'h1, gap[1] >= 4)
        $display("test tracking done");
        for (g = 1; g >= 0; g--) begin
            pos[0] = 16'(rnd());
            for (k = 0; k < 6; k++) begin
                mm = mode_e'(k % 3 == 0 ? 0 : k % 3 + 1);
                if (g == 1) m1 = mm;
                else m0 = mm;
                {man, blw, hys, abv, pwm} = 14'($random(seed));
                repeat (3) @(negedge i_ref_clk);
                `CHK("group bits", mx(g, mm), drain_on[3*g+:3])
            end
            m0 = MODE_QUAD;
            m1 = MODE_QUAD;
            if (g == 1) begin
                settle(1);
                `CHK("bad0", 0, bad[0])
                `CHK("gap0", 1'h1, gap[0] >= 4)
            end
        end
        `CHK("drain level", 6'h0, drain_level)
        $display("test modes done");
        close_out();
    end
endmodule
